/* File: bench/lowpower_dram_channel_interface_test.sv */
`timescale 1ns/10ps
module lowpower_dram_channel_interface_test
  import lpdci_pkg::*;
;
  localparam logic [ROW_W-1:0] ROW = 15'h5A3C;
  localparam logic [COL_W-1:0] COL = 10'h2AF;
  logic              ref_clk, nrst, op_valid, op_bl32, pd_req, dbi_en, ca_term_en;
  logic              op_ready, op_err, wr_data_req, rd_data_valid, init_done, clock_true;
  logic              clock_comp, clock_enable_out, chip_select, ca_termination_pin;
  logic              reset_low, dq_oe, dqs_oe, dmi_oe, rd_strobe_clk;
  logic [1:0]        op_kind;
  logic [2:0]        op_len;
  logic [4*CA_W-1:0] op_ca;
  logic [BANK_W-1:0] op_bank;
  logic [ROW_W-1:0]  op_row;
  logic [COL_W-1:0]  op_col;
  logic [2*DQ_W-1:0] wr_data, rd_data;
  logic [CA_W-1:0]   cmd_addr_bus;
  logic [DQ_W-1:0]   dq_out, dq_in;
  logic [LANES-1:0]  dqs_t_out, dqs_c_out, dmi_out, dmi_in;
  int                error_cnt = 0, checks = 0, cyc = 0, errs = 0, early = 0, n;
  int                rvals = 0;
  logic              term_lv;
  lpdci_host uut (.ref_clk, .nrst, .rd_strobe_clk, .op_valid, .op_kind, .op_ca, .op_len,
    .op_bank, .op_row, .op_col, .op_bl32, .op_ready, .op_err, .wr_data, .wr_data_req,
    .rd_data, .rd_data_valid, .pd_req, .dbi_en, .ca_term_en, .init_done, .clock_true,
    .clock_comp, .clock_enable_out, .chip_select, .cmd_addr_bus, .ca_termination_pin,
    .reset_low, .dq_out, .dq_oe, .dq_in, .dqs_t_out, .dqs_c_out, .dqs_oe, .dmi_out,
    .dmi_oe, .dmi_in);
  lpdci_dev_model dev (.ref_clk, .clock_true, .clock_enable_out, .chip_select,
    .cmd_addr_bus, .reset_low, .dq_out, .dq_oe, .dqs_oe, .dmi_out, .rd_strobe_clk,
    .dq_in, .dmi_in);
  // Low-voltage build beside the main one; only its termination pin is watched
  lpdci_host #(.LOW_IO_VARIANT(1'b1)) uut_lv (.ref_clk, .nrst, .rd_strobe_clk, .op_valid,
    .op_kind, .op_ca, .op_len, .op_bank, .op_row, .op_col, .op_bl32, .op_ready(), .op_err(),
    .wr_data, .wr_data_req(), .rd_data(), .rd_data_valid(), .pd_req, .dbi_en, .ca_term_en,
    .init_done(), .clock_true(), .clock_comp(), .clock_enable_out(), .chip_select(),
    .cmd_addr_bus(), .ca_termination_pin(term_lv), .reset_low(), .dq_out(), .dq_oe(),
    .dq_in, .dqs_t_out(), .dqs_c_out(), .dqs_oe(), .dmi_out(), .dmi_oe(), .dmi_in);
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Request held until the edge that samples ready high
  task automatic req(input lpdci_op_t k, input logic [BANK_W-1:0] b, input logic bl);
    int w;
    op_kind <= k;
    op_ca <= 24'(k);
    op_bank <= b;
    op_bl32 <= bl;
    op_valid <= 1'b1;
    w = 0;
    do @(posedge ref_clk); while (op_ready !== 1'b1 && ++w < 300);
    op_valid <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic chk_cmd(input logic [4*CA_W-1:0] e);
    for (int i = 0; i < 4; i++)
      cmp(32'(dev.words[i]), 32'(e[6*i+:6]));
    cmp(32'(dev.cs_seen), 32'h5);
  endtask
  // Rising beat first; pairs kept well over 5 cycles apart
  task automatic rd_chk(input logic [DQ_W-1:0] d0, input logic [1:0] m0, input logic [31:0] e);
    dev.read_pair(d0, 16'h3C3C, m0, 2'h0);
    repeat (8) @(posedge ref_clk);
    cmp(rd_data, e);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Sticky views of pulses; a hang ends the run as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (op_err === 1'b1) errs++;
    if (rd_data_valid === 1'b1) rvals++;
    if (op_ready === 1'b1 && init_done !== 1'b1) early++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  // Write word placed in the cycle after each request
  always @(posedge ref_clk) if (wr_data_req === 1'b1) wr_data <= 32'h0F0F12FF;
  initial begin
    {nrst, op_valid, op_bl32, pd_req, op_kind, op_ca, op_bank, op_col, wr_data} = '0;
    {op_len, op_row, op_col, dbi_en, ca_term_en} = {3'h4, ROW, COL, 2'h3};
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    n = 0;
    do @(posedge ref_clk); while (init_done !== 1'b1 && ++n < 300);
    cmp(32'(reset_low), 32'h1);
    cmp(32'(clock_enable_out), 32'h1);
    cmp(32'(ca_termination_pin), 32'h1);
    cmp(32'(term_lv), 32'h0);
    cmp(32'(early), 32'h0);
    req(LPDCI_OP_RD, 3'h5, 1'b0);
    cmp(32'(errs), 32'h1);
    cmp(32'(dev.ncmd), 32'h0);
    req(LPDCI_OP_ACT, 3'h3, 1'b0);
    chk_cmd({ROW[5:0], ROW[11:6], ROW[14:12], 3'h3, 6'h01});
    req(LPDCI_OP_WR, 3'h3, 1'b0);
    chk_cmd({4'h0, COL[3:2], COL[9:4], 3'h0, 3'h3, 6'h03});
    req(LPDCI_OP_WR, 3'h3, 1'b1);
    n = 0;
    do @(posedge ref_clk); while (dev.beats < 48 && ++n < 300);
    repeat (20) @(posedge ref_clk);
    cmp(32'(dev.beats), 32'h30);
    cmp(32'(dev.pre), 32'(WPRE_CYC));
    cmp(32'(dev.beat0), 32'h1200);
    cmp(32'(dev.dmi0), 32'h1);
    rd_chk(16'h00ED, 2'h1, 32'h3C3C0012);
    dbi_en <= 1'b0;
    rd_chk(16'h00ED, 2'h3, 32'h3C3C00ED);
    cmp(32'(rvals), 32'h2);
    req(LPDCI_OP_WR, 3'h3, 1'b0);
    repeat (40) @(posedge ref_clk);
    cmp(32'(dev.beats), 32'h40);
    pd_req <= 1'b1;
    repeat (20) @(posedge ref_clk);
    cmp(32'(clock_enable_out), 32'h0);
    pd_req <= 1'b0;
    ca_term_en <= 1'b0;
    repeat (20) @(posedge ref_clk);
    cmp(32'(clock_enable_out), 32'h1);
    cmp(32'(ca_termination_pin), 32'h0);
    req(LPDCI_OP_RAW, 3'h0, 1'b0);
    chk_cmd(24'h0);
    req(LPDCI_OP_RD, 3'h3, 1'b0);
    cmp(32'(errs), 32'h2);
    summarize();
  end
endmodule

/* File: bench/lpdci_dev_model.sv */
`timescale 1ns/10ps
module lpdci_dev_model
  import lpdci_pkg::*;
(
  input  wire logic             ref_clk,          // Beat clock
  input  wire logic             clock_true,       // Link clock
  input  wire logic             clock_enable_out, // Enable pin
  input  wire logic             chip_select,      // Select pin
  input  wire logic [CA_W-1:0]  cmd_addr_bus,     // Command words
  input  wire logic             reset_low,        // Reset pin
  input  wire logic [DQ_W-1:0]  dq_out,           // Write beats
  input  wire logic             dq_oe,            // Beats driven
  input  wire logic             dqs_oe,           // Strobe driven
  input  wire logic [LANES-1:0] dmi_out,          // Write inversion
  output logic                  rd_strobe_clk,    // Read strobe
  output logic [DQ_W-1:0]       dq_in,            // Read beats
  output logic [LANES-1:0]      dmi_in            // Read inversion
);
  logic [CA_W-1:0]  words [4];
  logic [3:0]       cs_seen;
  logic [DQ_W-1:0]  beat0;
  logic [LANES-1:0] dmi0;
  int               wcnt = 0, ncmd = 0, beats = 0, pre = 0;
  // Words only on rising link clock, enabled and out of reset
  always @(posedge clock_true or negedge reset_low) begin
    if (!reset_low) begin
      wcnt = 0;
    end else if (clock_enable_out && (wcnt > 0 || chip_select)) begin
      words[wcnt] = cmd_addr_bus;
      cs_seen[wcnt] = chip_select;
      wcnt = (wcnt + 1) % 4;
      if (wcnt == 0) ncmd++;
    end
  end
  // Beats taken mid-cycle, clear of the launching edge
  always @(negedge ref_clk) begin
    if (dqs_oe && !dq_oe && beats == 0) pre++;
    if (dq_oe && beats == 0) {beat0, dmi0} = {dq_out, dmi_out};
    if (dq_oe) beats++;
  end
  // Data leads the strobe by 2 ns so capture never races it
  task automatic read_pair(input logic [DQ_W-1:0] d0, d1,
                           input logic [LANES-1:0] m0, m1);
    dq_in = d0;
    dmi_in = m0;
    #2 rd_strobe_clk = 1'b1;
    #13 dq_in = d1;
    dmi_in = m1;
    #2 rd_strobe_clk = 1'b0;
    #13 dq_in = ~d1;
    dmi_in = ~m1;
  endtask
  // Strobe still between frames
  initial {rd_strobe_clk, dq_in, dmi_in} = {1'b0, 16'h5A5A, 2'h2};
endmodule

/* File: rtl/lpdci_host.sv */
`timescale 1ns/10ps
// Functional notes
// - Each channel has its own clock pair, enable, select and command bus.
// - Power saving entered and left only by clock enable level changes.
// - Low-voltage variant ignores termination pin; pin held at a fixed level.
// - Controller drives the write strobe, starting before write data.
// - Each byte lane has its own strobe pair and mask/invert line.
// - Mask/invert line high when byte sent inverted, low when true.
// - Command bus is six bits carrying command, address and bank.
// - Commands take one, two or four cycles, sent on rising edges.
// - Each data line moves two bits per clock, one per half.
// - Controller activates a row before reading or writing that bank.
// - Controller finishes initialisation before normal read or write traffic.
// - Two lowest column bits are zero and never sent.
// - Burst length sixteen or thirty-two, per command.
module lpdci_host
  import lpdci_pkg::*;
#(
  parameter bit LOW_IO_VARIANT = 1'b0
) (
  input  wire logic                ref_clk,            // System clock
  input  wire logic                nrst,               // Async reset, active low
  input  wire logic                rd_strobe_clk,      // Read strobe from device
  input  wire logic                op_valid,           // Command request
  input  wire logic [1:0]          op_kind,            // lpdci_op_t code
  input  wire logic [4*CA_W-1:0]   op_ca,              // Raw words / command code
  input  wire logic [2:0]          op_len,             // Raw length: 1, 2 or 4
  input  wire logic [BANK_W-1:0]   op_bank,            // Bank address
  input  wire logic [ROW_W-1:0]    op_row,             // Row address
  input  wire logic [COL_W-1:0]    op_col,             // Column address
  input  wire logic                op_bl32,            // Burst of 32 beats
  output logic                     op_ready,           // Request may be taken
  output logic                     op_err,             // Request refused pulse
  input  wire logic [2*DQ_W-1:0]   wr_data,            // Two write beats
  output logic                     wr_data_req,        // Write word wanted next cycle
  output logic [2*DQ_W-1:0]        rd_data,            // Two read beats
  output logic                     rd_data_valid,      // Read word pulse
  input  wire logic                pd_req,             // Power-down request level
  input  wire logic                dbi_en,             // Inversion enabled
  input  wire logic                ca_term_en,         // Command termination on
  output logic                     init_done,          // Init sequence finished
  output logic                     clock_true,         // Link clock, true
  output logic                     clock_comp,         // Link clock, complement
  output logic                     clock_enable_out,   // Clock enable pin
  output logic                     chip_select,        // Select pin
  output logic [CA_W-1:0]          cmd_addr_bus,       // Command/address pins
  output logic                     ca_termination_pin, // Termination control pin
  output logic                     reset_low,          // Device reset, active low
  output logic [DQ_W-1:0]          dq_out,             // Data pins out
  output logic                     dq_oe,              // Data pins driven
  input  wire logic [DQ_W-1:0]     dq_in,              // Data pins in
  output logic [LANES-1:0]         dqs_t_out,          // Write strobe true
  output logic [LANES-1:0]         dqs_c_out,          // Write strobe complement
  output logic                     dqs_oe,             // Strobe driven
  output logic [LANES-1:0]         dmi_out,            // Inversion lines out
  output logic                     dmi_oe,             // Inversion lines driven
  input  wire logic [LANES-1:0]    dmi_in              // Inversion lines in
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_RESET, S_CKE_WAIT, S_IDLE, S_CMD, S_WPRE, S_WDATA}
    lpdci_state_t;

  lpdci_state_t          st_r, st_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [2:0]            widx_r;
  logic [2:0]            wlen_r;
  logic [4*CA_W-1:0]     words_r;
  logic [1:0]            kind_r;
  logic                  bl32_r;
  logic [BANKS-1:0]      open_r;
  logic                  clk_r, clkc_r;
  logic                  cke_r, cs_r, rst_pin_r, term_r, ready_r, err_r, done_r;
  logic [CA_W-1:0]       ca_r;
  logic [DQ_W-1:0]       dq_r;
  logic                  dq_oe_r, dqs_oe_r, dmi_oe_r, wreq_r;
  logic [LANES-1:0]      dqs_r, dqsc_r, dmi_r;
  logic [DQ_W-1:0]       hi_beat_r;
  logic [2*DQ_W-1:0]     rdat_r;
  logic                  rvld_r;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Accept only on the high phase so new words appear on the falling edge
  wire phase_hi   = clk_r;
  wire is_access  = (op_kind == LPDCI_OP_RD) || (op_kind == LPDCI_OP_WR);
  wire bank_open  = open_r[op_bank];
  wire refuse     = is_access && !bank_open;
  wire take       = (st_r == S_IDLE) && op_valid && phase_hi && cke_r;
  wire go         = take && !refuse;
  wire [2:0] len  = (op_kind == LPDCI_OP_RAW) ? op_len : 3'(CMD_WORDS_FIX);

  // Activate words: code, row top with bank, then two row slices
  wire [4*CA_W-1:0] act_words = {op_ca[CA_W-1:0], op_row[14:12], op_bank,
                                 op_row[11:6], op_row[5:0]};
  // Access words: code, burst flag with bank, column without two low bits
  wire [4*CA_W-1:0] acc_words = {op_ca[CA_W-1:0], op_bl32, 2'h0, op_bank,
                                 op_col[9:4], 4'h0, op_col[3:COL_DROP]};
  wire [4*CA_W-1:0] raw_words = {op_ca[CA_W-1:0], op_ca[2*CA_W-1:CA_W],
                                 op_ca[3*CA_W-1:2*CA_W], op_ca[4*CA_W-1:3*CA_W]};
  wire [4*CA_W-1:0] sel_words = (op_kind == LPDCI_OP_ACT) ? act_words :
                                (op_kind == LPDCI_OP_RAW) ? raw_words : acc_words;

  // Last-word flag and burst length of the command in flight
  wire            last_word = (widx_r + 3'h1 == wlen_r);
  wire [CNT_W-1:0] beats   = bl32_r ? CNT_W'(BEATS_BL32) : CNT_W'(BEATS_BL16);

  // ----------------------------------------------------------------
  // Write inversion per byte lane
  // ----------------------------------------------------------------
  // Beat of the current ref cycle: low half first, high half next
  wire [DQ_W-1:0]  beat_raw = cnt_r[0] ? hi_beat_r : wr_data[DQ_W-1:0];
  wire [LANES-1:0] inv_w;
  wire [DQ_W-1:0]  beat_out;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      wire [7:0] b = beat_raw[8*g +: 8];
      wire [3:0] ones = 4'(b[0]) + 4'(b[1]) + 4'(b[2]) + 4'(b[3]) +
                        4'(b[4]) + 4'(b[5]) + 4'(b[6]) + 4'(b[7]);
      // Inverting heavy bytes cuts the number of driven ones
      assign inv_w[g] = dbi_en && (ones > 4'h4);
      assign beat_out[8*g +: 8] = inv_w[g] ? ~b : b;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    case (st_r)
      S_RESET: begin
        if (cnt_r == CNT_W'(RESET_HOLD_CYC - 1)) begin
          st_nxt  = S_CKE_WAIT;
          cnt_nxt = '0;
        end
      end
      S_CKE_WAIT: begin
        if (cnt_r == CNT_W'(CKE_DELAY_CYC - 1)) begin
          st_nxt  = S_IDLE;
          cnt_nxt = '0;
        end
      end
      S_IDLE: begin
        cnt_nxt = '0;
        if (go) begin
          st_nxt = S_CMD;
        end
      end
      S_CMD: begin
        cnt_nxt = '0;
        if (phase_hi && last_word) begin
          st_nxt = (kind_r == LPDCI_OP_WR) ? S_WPRE : S_IDLE;
        end
      end
      S_WPRE: begin
        if (cnt_r == CNT_W'(WPRE_CYC - 1)) begin
          st_nxt  = S_WDATA;
          cnt_nxt = '0;
        end
      end
      S_WDATA: begin
        if (cnt_r == beats - CNT_W'(1)) begin
          st_nxt  = S_IDLE;
          cnt_nxt = '0;
        end
      end
      default: begin
        st_nxt  = S_RESET;
        cnt_nxt = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer, clock divider and command pins
  // ----------------------------------------------------------------
  // Divide by two; the device samples on the rising edge of clock_true
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r  <= S_RESET;
      cnt_r <= '0;
      clk_r  <= 1'b0;
      clkc_r <= 1'b1;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      clk_r <= ~clk_r;
      // Own flop for the complement, so no gate sits behind the pin
      clkc_r <= clk_r;
    end
  end

  // Command words change only on the falling edge of clock_true
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      words_r <= '0;
      widx_r  <= '0;
      wlen_r  <= '0;
      kind_r  <= LPDCI_OP_RAW;
      bl32_r  <= 1'b0;
      ca_r    <= CA_IDLE;
      cs_r    <= 1'b0;
    end else if (go) begin
      words_r <= sel_words;
      widx_r  <= '0;
      wlen_r  <= len;
      kind_r  <= op_kind;
      bl32_r  <= op_bl32;
      ca_r    <= sel_words[4*CA_W-1 -: CA_W];
      cs_r    <= 1'b1;
    end else if (st_r == S_CMD && phase_hi && !last_word) begin
      words_r <= {words_r[3*CA_W-1:0], CA_IDLE};
      widx_r  <= widx_r + 3'h1;
      ca_r    <= words_r[3*CA_W-1 -: CA_W];
      cs_r    <= widx_r[0];
    end else if (phase_hi) begin
      ca_r    <= CA_IDLE;
      cs_r    <= 1'b0;
    end
  end

  // Reset pin, clock enable, termination and open-row map
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pin_r <= 1'b0;
      cke_r     <= 1'b0;
      term_r    <= 1'b0;
      open_r    <= '0;
      done_r    <= 1'b0;
    end else begin
      rst_pin_r <= (st_r != S_RESET);
      // Level changes only between commands, never inside one
      if (st_r == S_CKE_WAIT && cnt_r == CNT_W'(CKE_DELAY_CYC - 1)) begin
        cke_r <= 1'b1;
      end else if (st_r == S_IDLE && phase_hi && !go) begin
        cke_r <= !pd_req;
      end
      // Low-voltage parts ignore the pin, so hold it at ground
      term_r <= LOW_IO_VARIANT ? 1'b0 : ca_term_en;
      if (go && op_kind == LPDCI_OP_ACT) begin
        open_r[op_bank] <= 1'b1;
      end else if (go && op_kind == LPDCI_OP_RAW) begin
        open_r <= '0;
      end
      if (st_r == S_CKE_WAIT && st_nxt == S_IDLE) begin
        done_r <= 1'b1;
      end
    end
  end

  // Handshake to the user side
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      ready_r <= (st_nxt == S_IDLE) && !clk_r && cke_r;
      err_r   <= take && refuse;
    end
  end

  // ----------------------------------------------------------------
  // Write data path
  // ----------------------------------------------------------------
  // Strobe driven low through the preamble, toggling with each beat
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dq_r      <= '0;
      dq_oe_r   <= 1'b0;
      dqs_r     <= '0;
      dqs_oe_r  <= 1'b0;
      dqsc_r    <= '1;
      dmi_r     <= '0;
      dmi_oe_r  <= 1'b0;
      wreq_r    <= 1'b0;
      hi_beat_r <= '0;
    end else begin
      dqs_oe_r <= (st_r == S_WPRE) || (st_r == S_WDATA);
      dqs_r    <= (st_r == S_WDATA) ? ~dqs_r : '0;
      dqsc_r   <= (st_r == S_WDATA) ? dqs_r : '1;
      dq_oe_r  <= (st_r == S_WDATA);
      dmi_oe_r <= (st_r == S_WDATA) && dbi_en;
      if (st_r == S_WDATA) begin
        dq_r  <= beat_out;
        dmi_r <= inv_w;
      end else begin
        dq_r  <= '0;
        dmi_r <= '0;
      end
      if (st_r == S_WDATA && !cnt_r[0]) begin
        hi_beat_r <= wr_data[2*DQ_W-1:DQ_W];
      end
      // Ask two edges ahead of each even beat so a registered source keeps up
      wreq_r <= ((st_nxt == S_WPRE) && (cnt_nxt == CNT_W'(WPRE_CYC - 1))) ||
                ((st_nxt == S_WDATA) && cnt_nxt[0] && (cnt_nxt != beats - CNT_W'(1)));
    end
  end

  // ----------------------------------------------------------------
  // Read capture on the device strobe
  // ----------------------------------------------------------------
  logic [DQ_W-1:0]  rs_lo_r, rs_hi_r;
  logic [LANES-1:0] rs_lom_r, rs_him_r;
  logic             rs_tog_r;

  // Device owns the strobe; data edge-aligned, first beat on rise
  always_ff @(posedge rd_strobe_clk or negedge nrst) begin
    if (!nrst) begin
      rs_lo_r  <= '0;
      rs_lom_r <= '0;
    end else begin
      rs_lo_r  <= dq_in;
      rs_lom_r <= dmi_in;
    end
  end

  // Second beat and a toggle marking a finished pair
  always_ff @(negedge rd_strobe_clk or negedge nrst) begin
    if (!nrst) begin
      rs_hi_r  <= '0;
      rs_him_r <= '0;
      rs_tog_r <= 1'b0;
    end else begin
      rs_hi_r  <= dq_in;
      rs_him_r <= dmi_in;
      rs_tog_r <= ~rs_tog_r;
    end
  end

  // Toggle crossing; the pair stays stable for half a strobe period, until the next rising strobe edge
  logic tog_s1_r, tog_s2_r, tog_s3_r;
  wire  rd_evt = tog_s2_r ^ tog_s3_r;
  wire [LANES-1:0] m_lo = dbi_en ? rs_lom_r : '0;
  wire [LANES-1:0] m_hi = dbi_en ? rs_him_r : '0;
  wire [DQ_W-1:0]  fix_lo = rs_lo_r ^ {{8{m_lo[1]}}, {8{m_lo[0]}}};
  wire [DQ_W-1:0]  fix_hi = rs_hi_r ^ {{8{m_hi[1]}}, {8{m_hi[0]}}};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      rvld_r   <= 1'b0;
      rdat_r   <= '0;
    end else begin
      tog_s1_r <= rs_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      rvld_r   <= rd_evt;
      if (rd_evt) begin
        rdat_r <= {fix_hi, fix_lo};
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign clock_true         = clk_r;
  assign clock_comp         = clkc_r;
  assign clock_enable_out   = cke_r;
  assign chip_select        = cs_r;
  assign cmd_addr_bus       = ca_r;
  assign ca_termination_pin = term_r;
  assign reset_low          = rst_pin_r;
  assign dq_out             = dq_r;
  assign dq_oe              = dq_oe_r;
  assign dqs_t_out          = dqs_r;
  assign dqs_c_out          = dqsc_r;
  assign dqs_oe             = dqs_oe_r;
  assign dmi_out            = dmi_r;
  assign dmi_oe             = dmi_oe_r;
  assign op_ready           = ready_r;
  assign op_err             = err_r;
  assign wr_data_req        = wreq_r;
  assign rd_data            = rdat_r;
  assign rd_data_valid      = rvld_r;
  assign init_done          = done_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic [CNT_W-1:0] wbeat_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wbeat_r <= '0;
    end else begin
      wbeat_r <= dq_oe_r ? wbeat_r + CNT_W'(1) : '0;
    end
  end

  sequence s_cmd4;
    (st_r == S_CMD)[*8];
  endsequence
  sequence s_strobe_lead;
    dqs_oe_r && !dq_oe_r ##1 dqs_oe_r && !dq_oe_r;
  endsequence

  a_ca_on_fall: assert property ($changed(ca_r) |-> $fell(clk_r))
    else $error("command bus changed off the falling edge");
  a_clk_pair: assert property (clock_comp == ~clock_true)
    else $error("clock pair not complementary");
  a_cke_idle: assert property ($fell(cke_r) |-> $past(st_r) == S_IDLE)
    else $error("clock enable dropped outside idle");
  a_cmd_len4: assert property ($rose(st_r == S_CMD) && wlen_r == 3'h4 |-> s_cmd4)
    else $error("four-word command not sent back to back");
  a_act_first: assert property ($rose(st_r == S_CMD) && kind_r[1] |-> $past(bank_open))
    else $error("access issued to a closed bank");
  a_data_init: assert property (dq_oe_r |-> done_r && cke_r)
    else $error("write data before initialisation");
  a_strobe_lead: assert property ($rose(dqs_oe_r) |-> s_strobe_lead)
    else $error("write strobe did not lead data");
  a_dbi_off: assert property (!dbi_en && dq_oe_r |-> dmi_r == '0 && $past(dqs_oe_r))
    else $error("inversion signalled while disabled");
  a_burst_len: assert property ($fell(dq_oe_r) |->
                               wbeat_r == CNT_W'(BEATS_BL16) ||
                               wbeat_r == CNT_W'(BEATS_BL32))
    else $error("write burst length wrong");
  a_reset_cke: assert property (!rst_pin_r |-> !cke_r && !dq_oe_r)
    else $error("device active during reset");

endmodule

/* File: rtl/lpdci_pkg.sv */
package lpdci_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CA_W      = 6;
  localparam int DQ_W      = 16;
  localparam int LANES     = 2;
  localparam int BANKS     = 8;
  localparam int BANK_W    = 3;
  localparam int ROW_W     = 15;
  localparam int COL_W     = 10;
  localparam int COL_DROP  = 2;
  localparam int CNT_W     = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_MHZ    = 250;
  localparam int RESET_HOLD_NS  = 200;
  localparam int CKE_DELAY_NS   = 100;
  // Least times, rounded up to whole cycles
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int CKE_DELAY_CYC  = (CKE_DELAY_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int WRITE_LAT_LINK = 8;
  localparam int WPRE_CYC       = 2 * WRITE_LAT_LINK;
  localparam int BEATS_BL16     = 16;
  localparam int BEATS_BL32     = 32;
  localparam int CMD_WORDS_FIX  = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CA_W-1:0] CA_IDLE = 6'h00;

  typedef enum logic [1:0] {
    LPDCI_OP_RAW,
    LPDCI_OP_ACT,
    LPDCI_OP_RD,
    LPDCI_OP_WR
  } lpdci_op_t;
endpackage
